// ### src/ssp_pkg.sv
// Shared constants and types of the synchronous serial pipe protocol block.
// Assumes one core clock domain.
package ssp_pkg;

    // ------------------------------------------------------------------
    // Opcodes, first byte of every transfer
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_READ_PROTO_INFORMATION   = 8'h01;
    localparam logic [7:0] OP_WRITE_PROTO_SETTINGS     = 8'h02;
    localparam logic [7:0] OP_COMMAND_INBOUND_CHANNEL  = 8'h03;
    localparam logic [7:0] OP_QUEUE_SIZE_REPORT        = 8'h04;
    localparam logic [7:0] OP_NOTICE_OUTBOUND_CHANNEL  = 8'h05;
    localparam logic [7:0] OP_SAMPLE_OUTBOUND_CHANNEL  = 8'h06;

    // ------------------------------------------------------------------
    // Ready line settings byte layout
    // ------------------------------------------------------------------
    localparam int         CFG_MEAS_QUEUE_EVENT_EN_BIT  = 3;
    localparam int         CFG_NOTIF_QUEUE_EVENT_EN_BIT = 2;
    localparam int         CFG_LINE_DRIVER_KIND_BIT     = 1;
    localparam int         CFG_LINE_IDLE_LEVEL_BIT      = 0;
    localparam logic [7:0] CFG_RESET                    = 8'h0C;
    localparam logic [7:0] CFG_USED_MASK                = 8'h0F;

    // ------------------------------------------------------------------
    // Strap codes {iface_select_high, iface_select_low}
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_I2C       = 2'h3;
    localparam logic [1:0] STRAP_SPI       = 2'h2;
    localparam logic [1:0] STRAP_UART_HALF = 2'h1;
    localparam logic [1:0] STRAP_UART_FULL = 2'h0;

    // ------------------------------------------------------------------
    // Fixed answer lengths in bytes
    // ------------------------------------------------------------------
    localparam logic [15:0] INFO_LEN   = 16'h0002;
    localparam logic [15:0] STATUS_LEN = 16'h0004;

    typedef enum logic [1:0] {
        SSP_IF_I2C,
        SSP_IF_SPI,
        SSP_IF_UART_HALF,
        SSP_IF_UART_FULL
    } ssp_iface_type;

    typedef struct packed {
        logic       sck;
        logic       mosi;
        logic       cs_n;
    } ssp_link_type;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ssp_push_type;

    typedef struct packed {
        logic       byte_valid;
        logic       msg_end;
        logic [7:0] data;
    } ssp_cmd_type;

endpackage

// ### src/ssp_core.sv
// Host interface logic: straps, opcode protocol, pipes, data-waiting line.
// Assumes link pins come from outside the core_clk domain and that the
// interpreter and measurement source sit on core_clk.
//
// Functional notes
// - Select pins sampled only at reset; change pins then reset to switch.
// - Straps {high,low}: 11 I2C, 10 SPI, 01 UART half, 00 UART full.
// - Unconnected straps read as 1, giving I2C by default.
// - UART carries messages unchanged; I2C/SPI use the opcode pipe protocol. Only the SPI link is built here; I2C and UART modes stay idle.
// - Device is slave only; host starts every transfer.
// - All data bytes of one command write form exactly one command message.
// - Interpreter answers go to the notification pipe for host reads.
// - Host switches setup and sampling modes through command messages.
// - In sampling mode measurement messages enter the measurement pipe.
// - Status read gives next pending message size of both read pipes.
// - Data-waiting line active while any pipe holds a message.
// - First byte of every transfer is the opcode deciding its meaning.
// - Opcodes 01 info read, 02 settings write, 03 command write.
// - Opcodes 04 status read, 05 notification read, 06 measurement read.
// - Pipe messages are reduced: preamble and bus ident bytes omitted.
// - Reduced message checksum still counts bus ident as FF.
// - Info read returns version byte then ready line settings byte.
// - Settings bit 3 enables measurement pipe events, default on.
// - Settings bit 2 enables notification pipe events, default on.
// - Settings bit 1 selects push-pull (0, default) or open-drain (1).
// - Settings bit 0 sets idle level; 1 inverts the active level.
// - Settings bits 7:4 reserved, read back as zero.
// - Settings write carries one byte in the same layout, applied at once.
// - Status read returns two little-endian 16-bit sizes, notification first.

// ----------------------------------------------------------------------
// Outbound pipe of one message
// ----------------------------------------------------------------------
module ssp_out_pipe #(
    parameter int DEPTH = 64,
    parameter int IW    = $clog2(DEPTH)
) (
    input  wire logic                  core_clk,    // Core clock
    input  wire logic                  reset,       // Synchronous reset
    input  wire logic                  enable,      // Pipe accepts bytes
    input  wire ssp_pkg::ssp_push_type push,        // Byte and end marker
    input  wire logic                  push_valid,  // Byte offered
    output logic                       push_ready,  // Byte may be taken
    input  wire logic [IW-1:0]         rd_idx,      // Read byte index
    output logic [7:0]                 rd_byte,     // Byte at index
    input  wire logic                  consume,     // Host read it all
    output logic [15:0]                size,        // Pending size, 0 if none
    output logic                       has_msg      // Complete message held
);
    import ssp_pkg::*;

    logic [7:0]    mem [DEPTH];
    logic [IW-1:0] wr_ptr;
    logic          full;
    wire           take      = push_valid & push_ready;
    wire           wr_end    = push.last | (wr_ptr == IW'(DEPTH - 1));
    wire           next_full = consume ? 1'b0 : (full | (take & wr_end));

    assign rd_byte = mem[rd_idx];
    assign has_msg = full;

    always_ff @(posedge core_clk) begin
        if (take) begin
            mem[wr_ptr] <= push.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr     <= '0;
            full       <= 1'b0;
            size       <= '0;
            push_ready <= 1'b0;
        end else begin
            full       <= next_full;
            push_ready <= ~next_full & enable;
            if (consume) begin
                wr_ptr <= '0;
                size   <= '0;
            end else if (take & wr_end) begin
                size <= 16'(wr_ptr) + 16'h0001;
            end else if (take) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end
endmodule // ssp_out_pipe

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module ssp_core #(
    parameter int         PIPE_DEPTH    = 64,
    parameter logic [7:0] PROTO_VERSION = 8'h01   // Arbitrary value
) (
    input  wire logic                  core_clk,            // 20 MHz core clock
    input  wire logic                  reset,               // Synchronous, active high
    input  wire logic                  iface_select_low,    // Strap pin, async
    input  wire logic                  iface_select_high,   // Strap pin, async
    input  wire ssp_pkg::ssp_link_type spi_link,            // SPI pins, async
    output ssp_pkg::ssp_iface_type     iface_mode,          // Selected interface
    output logic                       spi_miso,            // SPI data out
    output logic                       spi_miso_en,         // MISO driven
    output ssp_pkg::ssp_cmd_type       cmd_out,             // Command pipe stream
    input  wire logic                  sampling_mode,       // Interpreter is in sampling mode
    input  wire ssp_pkg::ssp_push_type notif_push,          // Notification byte
    input  wire logic                  notif_push_valid,    // Notification byte offered
    output logic                       notif_push_ready,    // Notification byte taken
    input  wire ssp_pkg::ssp_push_type meas_push,           // Measurement byte
    input  wire logic                  meas_push_valid,     // Measurement byte offered
    output logic                       meas_push_ready,     // Measurement byte taken
    output logic [7:0]                 ready_line_config,   // Active settings byte
    output logic                       data_waiting_line,   // Line level out
    output logic                       data_waiting_line_oe // Line driven
);
    import ssp_pkg::*;

    localparam int IW = $clog2(PIPE_DEPTH);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [1:0]   sel_s1;
    logic [1:0]   sel_s2;
    ssp_link_type link_s1;
    ssp_link_type link_s2;
    ssp_link_type link_s3;

    always_ff @(posedge core_clk) begin
        sel_s1 <= {iface_select_high, iface_select_low};
        sel_s2 <= sel_s1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            link_s1 <= '{sck: 1'b1, mosi: 1'b0, cs_n: 1'b1};
            link_s2 <= '{sck: 1'b1, mosi: 1'b0, cs_n: 1'b1};
            link_s3 <= '{sck: 1'b1, mosi: 1'b0, cs_n: 1'b1};
        end else begin
            link_s1 <= spi_link;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
        end
    end

    // ------------------------------------------------------------------
    // Interface select
    // ------------------------------------------------------------------
    ssp_iface_type strap_iface;

    always_comb begin
        unique case (sel_s2)
            STRAP_I2C:       strap_iface = SSP_IF_I2C;
            STRAP_SPI:       strap_iface = SSP_IF_SPI;
            STRAP_UART_HALF: strap_iface = SSP_IF_UART_HALF;
            default:         strap_iface = SSP_IF_UART_FULL;
        endcase
    end

    // caught only while reset is held
    always_ff @(posedge core_clk) begin
        if (reset) begin
            iface_mode <= strap_iface;
        end
    end

    // ------------------------------------------------------------------
    // Link framing, SPI mode 3, MSB first
    // ------------------------------------------------------------------
    // host drives every edge
    wire spi_on    = (iface_mode == SSP_IF_SPI);
    wire sck_rise  = link_s2.sck & ~link_s3.sck;
    wire cs_active = spi_on & ~link_s2.cs_n;
    wire cs_start  = spi_on & ~link_s2.cs_n & link_s3.cs_n;
    wire cs_end    = spi_on & link_s2.cs_n & ~link_s3.cs_n;

    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  opcode;
    logic        got_opcode;
    logic        data_seen;
    logic        drained;
    logic [15:0] tx_idx;

    wire [7:0] rx_next   = {rx_sh[6:0], link_s2.mosi};
    wire       byte_done = cs_active & sck_rise & (bit_cnt == 3'h7);
    wire       data_byte = byte_done & got_opcode;
    // opcode byte picks the meaning of what follows
    wire [7:0] op_sel    = got_opcode ? opcode : rx_next;

    // ------------------------------------------------------------------
    // Answer selection
    // ------------------------------------------------------------------
    logic [15:0] notif_size;
    logic [15:0] meas_size;
    logic [7:0]  notif_byte;
    logic [7:0]  meas_byte;
    logic        notif_has;
    logic        meas_has;
    logic [15:0] resp_len;
    logic [7:0]  resp_raw;

    wire [15:0] idx_inc  = tx_idx + 16'h0001;
    wire [15:0] load_idx = (~got_opcode | (idx_inc >= resp_len)) ? 16'h0000 : idx_inc;
    wire [7:0]  resp_byte = (resp_len == 16'h0000) ? 8'h00 : resp_raw;

    always_comb begin
        unique case (op_sel)
            OP_READ_PROTO_INFORMATION:  resp_len = INFO_LEN;
            OP_QUEUE_SIZE_REPORT:       resp_len = STATUS_LEN;
            OP_NOTICE_OUTBOUND_CHANNEL: resp_len = notif_size;
            OP_SAMPLE_OUTBOUND_CHANNEL: resp_len = meas_size;
            default:                    resp_len = 16'h0000;
        endcase
    end

    // pipe bytes go out as stored, reduced form
    always_comb begin
        unique case (op_sel)
            OP_READ_PROTO_INFORMATION:
                resp_raw = load_idx[0] ? ready_line_config : PROTO_VERSION;
            OP_QUEUE_SIZE_REPORT: begin
                unique case (load_idx[1:0])
                    2'h0:    resp_raw = notif_size[7:0];
                    2'h1:    resp_raw = notif_size[15:8];
                    2'h2:    resp_raw = meas_size[7:0];
                    default: resp_raw = meas_size[15:8];
                endcase
            end
            OP_NOTICE_OUTBOUND_CHANNEL: resp_raw = notif_byte;
            OP_SAMPLE_OUTBOUND_CHANNEL: resp_raw = meas_byte;
            default:                    resp_raw = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset | cs_start) begin
            bit_cnt    <= '0;
            rx_sh      <= '0;
            opcode     <= '0;
            got_opcode <= 1'b0;
            data_seen  <= 1'b0;
            drained    <= 1'b0;
            tx_idx     <= '0;
        end else if (cs_active & sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_next;
            if (byte_done) begin
                got_opcode <= 1'b1;
                data_seen  <= got_opcode;
                tx_idx     <= load_idx;
                if (~got_opcode) begin
                    opcode <= rx_next;
                end
                if (got_opcode & (resp_len != 16'h0000) & (tx_idx == resp_len - 16'h0001)) begin
                    drained <= 1'b1;
                end
            end
        end
    end

    // Next bit set up after the host samples
    always_ff @(posedge core_clk) begin
        if (reset | cs_start) begin
            tx_sh    <= '0;
            spi_miso <= 1'b0;
        end else if (byte_done) begin
            tx_sh    <= resp_byte;
            spi_miso <= resp_byte[7];
        end else if (cs_active & sck_rise) begin
            tx_sh    <= {tx_sh[6:0], 1'b0};
            spi_miso <= tx_sh[6];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            spi_miso_en <= 1'b0;
        end else begin
            spi_miso_en <= spi_on & ~link_s2.cs_n & ~link_s3.cs_n;
        end
    end

    // ------------------------------------------------------------------
    // Settings and command pipe
    // ------------------------------------------------------------------
    // first settings byte applied
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ready_line_config <= CFG_RESET;
        end else if (data_byte & ~data_seen & (opcode == OP_WRITE_PROTO_SETTINGS)) begin
            ready_line_config <= rx_next & CFG_USED_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_out <= '0;
        end else begin
            cmd_out.byte_valid <= data_byte & (opcode == OP_COMMAND_INBOUND_CHANNEL);
            cmd_out.msg_end    <= cs_end & data_seen & (opcode == OP_COMMAND_INBOUND_CHANNEL);
            if (data_byte) begin
                cmd_out.data <= rx_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outbound pipes
    // ------------------------------------------------------------------
    // interpreter answers fill the notification pipe
    wire notif_consume = cs_end & drained & (opcode == OP_NOTICE_OUTBOUND_CHANNEL);
    wire meas_consume  = cs_end & drained & (opcode == OP_SAMPLE_OUTBOUND_CHANNEL);

    ssp_out_pipe #(
        .DEPTH      (PIPE_DEPTH),
        .IW         (IW)
    ) u_notif_pipe (
        .core_clk   (core_clk),
        .reset      (reset),
        .enable     (1'b1),
        .push       (notif_push),
        .push_valid (notif_push_valid),
        .push_ready (notif_push_ready),
        .rd_idx     (load_idx[IW-1:0]),
        .rd_byte    (notif_byte),
        .consume    (notif_consume),
        .size       (notif_size),
        .has_msg    (notif_has)
    );

    ssp_out_pipe #(
        .DEPTH      (PIPE_DEPTH),
        .IW         (IW)
    ) u_meas_pipe (
        .core_clk   (core_clk),
        .reset      (reset),
        .enable     (sampling_mode),
        .push       (meas_push),
        .push_valid (meas_push_valid),
        .push_ready (meas_push_ready),
        .rd_idx     (load_idx[IW-1:0]),
        .rd_byte    (meas_byte),
        .consume    (meas_consume),
        .size       (meas_size),
        .has_msg    (meas_has)
    );

    // ------------------------------------------------------------------
    // Data-waiting line
    // ------------------------------------------------------------------
    // active while a pipe holds a message
    wire line_active = (notif_has & ready_line_config[CFG_NOTIF_QUEUE_EVENT_EN_BIT])
                     | (meas_has & ready_line_config[CFG_MEAS_QUEUE_EVENT_EN_BIT]);
    // idle high inverts the active level
    wire line_level  = line_active ^ ready_line_config[CFG_LINE_IDLE_LEVEL_BIT];
    wire open_drain  = ready_line_config[CFG_LINE_DRIVER_KIND_BIT];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_waiting_line    <= 1'b0;
            data_waiting_line_oe <= 1'b1;
        end else begin
            data_waiting_line    <= open_drain ? 1'b0 : line_level;
            data_waiting_line_oe <= open_drain ? ~line_level : 1'b1;
        end
    end

endmodule // ssp_core

// ### dv/ssp_sva.sv
// Checker of the pipe protocol block ports.
// Assumes one core clock domain with a synchronous active-high reset.
module ssp_chk (
    input wire logic                   core_clk,            // Clock
    input wire logic                   reset,               // Reset
    input wire ssp_pkg::ssp_iface_type iface_mode,          // Interface
    input wire logic                   spi_miso_en,         // MISO driven
    input wire ssp_pkg::ssp_cmd_type   cmd_out,             // Command stream
    input wire logic                   sampling_mode,       // Sampling mode
    input wire logic                   notif_push_ready,    // Notice ready
    input wire logic                   meas_push_ready,     // Sample ready
    input wire logic [7:0]             ready_line_config,   // Settings
    input wire logic                   data_waiting_line,   // Line level
    input wire logic                   data_waiting_line_oe // Line driven
);
    timeunit 1ns;
    timeprecision 1ns;
    import ssp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_reserved_zero: assert property (ready_line_config[7:4] == 4'h0)
        else $error("reserved settings bits set");
    a_push_pull_oe: assert property (!$past(ready_line_config[1]) |-> data_waiting_line_oe)
        else $error("push-pull line not driven");
    a_open_drain_low: assert property ($past(ready_line_config[1]) |-> !data_waiting_line)
        else $error("open-drain line drives high");
    a_idle_level: assert property (notif_push_ready && meas_push_ready && $past(notif_push_ready)
        && $past(meas_push_ready) && $stable(ready_line_config) && !ready_line_config[1]
        |-> data_waiting_line == ready_line_config[0]) else $error("line not idle");
    a_notice_event: assert property ($fell(notif_push_ready) && ready_line_config[2] && !ready_line_config[1]
        && $stable(ready_line_config) |=> data_waiting_line != ready_line_config[0]) else $error("line not active");
    a_meas_gated: assert property (!$past(sampling_mode) && !$past(sampling_mode, 2) |-> !meas_push_ready)
        else $error("sample pipe open");
    a_mode_hold: assert property (!$past(reset) |-> $stable(iface_mode))
        else $error("interface changed");
    a_link_idle: assert property (iface_mode != SSP_IF_SPI |-> !spi_miso_en && !cmd_out.byte_valid)
        else $error("link active outside SPI");
    a_cmd_single: assert property (cmd_out.byte_valid |=> !cmd_out.byte_valid && !cmd_out.msg_end)
        else $error("command pulse too long");
    a_cfg_by_link: assert property ($changed(ready_line_config) |-> spi_miso_en && $past(spi_miso_en))
        else $error("settings changed outside a transfer");
endmodule // ssp_chk

bind ssp_core ssp_chk ssp_chk_inst (.core_clk, .reset, .iface_mode, .spi_miso_en, .cmd_out, .sampling_mode,
    .notif_push_ready, .meas_push_ready, .ready_line_config, .data_waiting_line, .data_waiting_line_oe);

// ### dv/ssp_host_model.sv
// Host controller model: SPI master in mode 3, bytes MSB first.
// Assumes one caller at a time; half sets the pace in core cycles.
module ssp_host_model (
    input  wire logic             core_clk, // Core clock
    output ssp_pkg::ssp_link_type link,     // SPI pins
    input  wire logic             miso      // Slave data out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ssp_pkg::*;
    int         half = 4;
    logic [7:0] rx [$];
    initial link = '{sck: 1'b1, mosi: 1'b1, cs_n: 1'b1};
    // master frames each transfer, opcode first
    task automatic xfer(input logic [7:0] tx [$]);
        logic [7:0] b;
        rx = {};
        @(posedge core_clk) link.cs_n <= 1'b0;
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                repeat (half) @(posedge core_clk);
                link.sck <= 1'b0;
                link.mosi <= tx[i][k];
                repeat (half - 1) @(posedge core_clk);
                @(negedge core_clk) b[k] = miso;
                @(posedge core_clk) link.sck <= 1'b1;
            end
            rx.push_back(b);
        end
        repeat (half) @(posedge core_clk);
        link.cs_n <= 1'b1;
        // Released data line shows no stale level
        link.mosi <= ~link.mosi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule // ssp_host_model

// ### dv/tb_top.sv
// Bench of the pipe protocol block over SPI.
// Assumes the host model drives the link.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ssp_pkg::*;
    localparam logic [7:0] VER = 8'h5A; // Arbitrary version value
    logic          core_clk = 1'b0, reset = 1'b1, iface_select_low = 1'b0, iface_select_high = 1'b1;
    logic          sampling_mode = 1'b0, notif_push_valid = 1'b0, meas_push_valid = 1'b0;
    ssp_push_type  notif_push = '0, meas_push = '0;
    ssp_link_type  spi_link;
    ssp_iface_type iface_mode;
    ssp_cmd_type   cmd_out;
    logic [7:0]    ready_line_config;
    logic [7:0]    cmd_q [$];
    logic          spi_miso, spi_miso_en, notif_push_ready, meas_push_ready, data_waiting_line, data_waiting_line_oe;
    int            err_count = 0, check_count = 0, ends = 0;
    ssp_core #(.PROTO_VERSION(VER)) ssp_core_inst (.core_clk, .reset, .iface_select_low, .iface_select_high,
        .spi_link, .iface_mode, .spi_miso, .spi_miso_en, .cmd_out, .sampling_mode, .notif_push, .notif_push_valid,
        .notif_push_ready, .meas_push, .meas_push_valid, .meas_push_ready, .ready_line_config,
        .data_waiting_line, .data_waiting_line_oe);
    ssp_host_model ssp_host_model_inst (.core_clk, .link(spi_link), .miso(spi_miso));
    initial forever #25 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (cmd_out.byte_valid === 1'b1) cmd_q.push_back(cmd_out.data);
        if (cmd_out.msg_end === 1'b1) ends++;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic xf(input logic [7:0] tx [$]);
        ssp_host_model_inst.xfer(tx);
    endtask
    function automatic logic [7:0] rx(input int i);
        return ssp_host_model_inst.rx[i];
    endfunction
    task automatic do_reset;
        reset <= 1'b1;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic chk_line(input logic [7:0] c, input logic act);
        repeat (3) @(posedge core_clk);
        chk("line", 8'(c[1] ? 1'b0 : act ^ c[0]), 8'(data_waiting_line));
        chk("line_oe", 8'(c[1] ? !(act ^ c[0]) : 1'b1), 8'(data_waiting_line_oe));
    endtask
    task automatic push(input logic meas, input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            notif_push <= '{base + 8'(i), i == n - 1};
            meas_push <= '{base + 8'(i), i == n - 1};
            meas_push_valid <= meas;
            notif_push_valid <= !meas;
            do @(negedge core_clk); while ((meas ? meas_push_ready : notif_push_ready) !== 1'b1);
            @(posedge core_clk);
        end
        meas_push_valid <= 1'b0;
        notif_push_valid <= 1'b0;
    endtask
    task automatic status(input logic [7:0] n, input logic [7:0] m);
        xf('{8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 4; i++) chk("status", i[0] ? 8'h00 : (i[1] ? m : n), rx(i + 1));
    endtask
    task automatic t_straps;
        ssp_iface_type exp [4] = '{SSP_IF_UART_FULL, SSP_IF_UART_HALF, SSP_IF_SPI, SSP_IF_I2C};
        for (int c = 0; c < 4; c++) begin
            {iface_select_high, iface_select_low} <= 2'(c);
            do_reset;
            chk("iface_mode", 8'(exp[c]), 8'(iface_mode));
        end
        xf('{8'h02, 8'h01});
        {iface_select_high, iface_select_low} <= STRAP_SPI;
        repeat (20) @(posedge core_clk);
        chk("mode_kept", 8'(SSP_IF_I2C), 8'(iface_mode));
        chk("cfg_no_spi", 8'h0C, ready_line_config);
        do_reset;
        chk("mode_new", 8'(SSP_IF_SPI), 8'(iface_mode));
        chk("cfg_reset", 8'h0C, ready_line_config);
        chk_line(8'h0C, 1'b0);
        $display("test straps done");
    endtask
    task automatic t_cfg;
        logic [7:0] vals [6] = '{8'hF4, 8'h08, 8'h05, 8'h06, 8'h07, 8'h0C};
        xf('{8'h01, 8'h00, 8'h00, 8'h00});
        chk("version", VER, rx(1));
        chk("settings", 8'h0C, rx(2));
        chk("info_again", VER, rx(3));
        push(1'b0, 3, 8'h40);
        foreach (vals[i]) begin
            xf('{8'h02, vals[i], 8'hFF});
            chk("cfg", vals[i] & 8'h0F, ready_line_config);
            chk_line(vals[i], vals[i][2]);
        end
        $display("test settings done");
    endtask
    task automatic t_notif;
        status(8'h03, 8'h00);
        xf('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 4; i++) chk("notice", 8'h40 + 8'(i % 3), rx(i + 1));
        chk_line(8'h0C, 1'b0);
        status(8'h00, 8'h00);
        $display("test notice done");
    endtask
    task automatic t_meas;
        meas_push_valid <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("meas_gated", 8'h00, 8'(meas_push_ready));
        meas_push_valid <= 1'b0;
        sampling_mode <= 1'b1;
        push(1'b1, 2, 8'h70);
        status(8'h00, 8'h02);
        chk_line(8'h0C, 1'b1);
        xf('{8'h02, 8'h04});
        chk_line(8'h04, 1'b0);
        xf('{8'h02, 8'h0C});
        xf('{8'h06, 8'h00, 8'h00});
        chk("sample0", 8'h70, rx(1));
        chk("sample1", 8'h71, rx(2));
        chk_line(8'h0C, 1'b0);
        $display("test sample done");
    endtask
    task automatic t_cmd;
        ssp_host_model_inst.half = 10;
        xf('{8'h03, 8'hA1, 8'hB2, 8'hC3});
        ssp_host_model_inst.half = 4;
        xf('{8'h07, 8'h55});
        xf('{8'h01, 8'h09});
        chk("cmd_count", 8'h03, 8'(cmd_q.size()));
        foreach (cmd_q[i]) chk("cmd_byte", 8'hA1 + 8'(8'h11 * i), cmd_q[i]);
        chk("cmd_end", 8'h01, 8'(ends));
        chk("cfg_kept", 8'h0C, ready_line_config);
        $display("test command done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        wrap_up;
    end
    initial begin
        t_straps;
        t_cfg;
        t_notif;
        t_meas;
        t_cmd;
        wrap_up;
    end
endmodule // tb_top
